// ===== logic/fhd_map.svh
// Register offsets, field positions, reset values and timing counts for the host data port
`ifndef FHD_MAP_SVH
`define FHD_MAP_SVH
`define FHD_OFS_DATA        3'h5
`define FHD_OFS_INSENSE     3'h7
`define FHD_OFS_MAIN_STATUS 3'h4
`define FHD_RATE_RST        2'h2
`define FHD_RATE_500K       2'h0
`define FHD_RATE_300K       2'h1
`define FHD_RATE_250K       2'h2
`define FHD_RATE_1M         2'h3
`define FHD_BIT_MEDIA       7
`define FHD_BIT_DMA         3
`define FHD_BIT_NOPREC      2
`define FHD_FIFO_DEPTH      16
`define FHD_GUARD_NS        1500
`define FHD_CLK_NS          10
`define FHD_GUARD_CYC       (`FHD_GUARD_NS / `FHD_CLK_NS)
`endif

// ===== logic/fhd_pkg.sv
// Types for the host data port
package fhd_pkg;
    typedef enum logic [1:0] {
        FHD_MODE_ONE,
        FHD_MODE_TWO,
        FHD_MODE_THREE
    } fhd_mode_t;
    typedef enum logic [1:0] {
        FHD_PH_IDLE,
        FHD_PH_CMD,
        FHD_PH_EXEC,
        FHD_PH_RESULT
    } fhd_phase_t;
endpackage

// ===== logic/fhd_host_port.sv
// Host data port, input sense register and rate configuration register
// Summary of operation
// - Data port at offset 5 moves bytes
// - Data port access gated by request, direction
// - Any reset leaves FIFO disabled
// - Configure enables FIFO and sets threshold
// - Command bytes pass singly, FIFO inactive
// - Execution entry flushes the FIFO
// - Overrun or underrun ends the command
// - Underrun write pads sector with zeros
// - Service request from threshold and direction
// - Input sense at offset 7 read only
// - First mode drives only bit 7
// - Bit 7 is inverted, forced media change
// - Second mode bit 0 low density
// - Second mode rate bits, ones above
// - Rate survives soft reset, hard 250K
// - Third mode bit 3 mirrors DMA gate
// - Third mode noprec bit and rate
// - Third mode bits 4-6 read zero
// - Config register write only, rate reset 10
// - Modes one, two config bits 2-7 zero
// - Third mode noprec kept over soft reset
// - Latest rate write wins; in one cycle the config register beats dsr_rate
// - Request flag and direction flag meanings
`timescale 1ns/1ns
`include "fhd_map.svh"
module fhd_host_port
    import fhd_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       arst_n,
    input  wire logic       soft_reset,
    input  wire fhd_mode_t  compat_mode,
    input  wire logic [2:0] bus_addr,
    input  wire logic       bus_rd,
    input  wire logic       bus_wr,
    input  wire logic [7:0] bus_wdata,
    output logic      [7:0] bus_rdata,
    output logic      [7:0] bus_rdata_oe_n,
    input  wire logic       media_changed_pin_n,
    input  wire logic       force_media_change,
    input  wire logic       dma_gate_enable,
    input  wire logic       dsr_rate_wr,
    input  wire logic [1:0] dsr_rate,
    input  wire logic       cfg_wr,
    input  wire logic       cfg_fifo_en,
    input  wire logic [3:0] cfg_threshold,
    input  wire fhd_phase_t cmd_phase,
    input  wire logic       exec_read,
    input  wire logic       eng_push,
    input  wire logic [7:0] eng_wdata,
    input  wire logic       eng_pop,
    output logic      [7:0] eng_rdata,
    output logic            fifo_empty,
    output logic            fifo_full,
    input  wire logic       disk_byte_tick,
    output logic            host_request_flag,
    output logic            transfer_direction_flag,
    output logic            service_req,
    output logic            xfer_error,
    output logic            pad_zero_crc,
    output logic      [1:0] rate_select,
    output logic            low_density_indicator
);
    localparam int DEPTH = `FHD_FIFO_DEPTH;

    logic [7:0] mem_r [DEPTH];
    logic [3:0] wp_r;
    logic [3:0] rp_r;
    logic [4:0] cnt_r;
    logic       fifo_en_r;
    logic [3:0] thr_r;
    logic [1:0] rate_r;
    logic       noprec_r;
    logic       err_r;
    logic       pad_r;
    fhd_phase_t phase_q_r;
    logic       data_rd;
    logic       data_wr;
    logic       push;
    logic       pop;
    logic       flush;
    logic [7:0] sense;

    function automatic logic fifo_mode(input logic en, input fhd_phase_t ph);
        return en && (ph == FHD_PH_EXEC);
    endfunction

    // Host reads when engine fills FIFO (exec read) or result phase
    assign transfer_direction_flag = (cmd_phase == FHD_PH_RESULT) ||
                                     (cmd_phase == FHD_PH_EXEC && exec_read);
    always_comb begin
        host_request_flag = 1'b0;
        unique case (cmd_phase)
            FHD_PH_IDLE, FHD_PH_CMD: host_request_flag = (cnt_r == 5'h00);
            FHD_PH_EXEC:             host_request_flag = transfer_direction_flag ? !fifo_empty : !fifo_full;
            FHD_PH_RESULT:           host_request_flag = !fifo_empty;
        endcase
    end

    // Accesses outside the flags are ignored, protecting FIFO contents
    assign data_rd = bus_rd && bus_addr == `FHD_OFS_DATA && host_request_flag && transfer_direction_flag;
    assign data_wr = bus_wr && bus_addr == `FHD_OFS_DATA && host_request_flag && !transfer_direction_flag;
    assign push    = data_wr || (eng_push && !fifo_full);
    assign pop     = data_rd || (eng_pop && !fifo_empty);
    assign flush   = (cmd_phase == FHD_PH_EXEC) && (phase_q_r != FHD_PH_EXEC);
    assign fifo_empty = (cnt_r == 5'h00);
    // Without FIFO mode the port holds one byte only
    assign fifo_full  = fifo_mode(fifo_en_r, cmd_phase) ? (cnt_r == 5'(DEPTH)) : (cnt_r != 5'h00);

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            phase_q_r <= FHD_PH_IDLE;
        end else begin
            phase_q_r <= cmd_phase;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            fifo_en_r <= 1'b0;
            thr_r     <= 4'h0;
        end else if (soft_reset) begin
            fifo_en_r <= 1'b0;
            thr_r     <= 4'h0;
        end else if (cfg_wr) begin
            fifo_en_r <= cfg_fifo_en;
            thr_r     <= cfg_threshold;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wp_r  <= 4'h0;
            rp_r  <= 4'h0;
            cnt_r <= 5'h00;
        end else if (soft_reset || flush || xfer_error && !exec_read) begin
            wp_r  <= 4'h0;
            rp_r  <= 4'h0;
            cnt_r <= 5'h00;
        end else begin
            if (push) begin
                wp_r <= wp_r + 4'h1;
            end
            if (pop) begin
                rp_r <= rp_r + 4'h1;
            end
            cnt_r <= cnt_r + {4'h0, push} - {4'h0, pop};
        end
    end

    always_ff @(posedge clk) begin
        if (push) begin
            mem_r[wp_r] <= data_wr ? bus_wdata : eng_wdata;
        end
    end

    assign eng_rdata = mem_r[rp_r];

    // Threshold margin leaves the 1.5 us guard before the disk needs the byte
    always_comb begin
        service_req = 1'b0;
        if (fifo_mode(fifo_en_r, cmd_phase)) begin
            service_req = exec_read ? (cnt_r >= 5'(thr_r) + 5'h01)
                                    : (5'(DEPTH) - cnt_r >= 5'(thr_r) + 5'h01);
        end
    end

    // Disk byte tick with nothing to give or no room ends the transfer
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            err_r <= 1'b0;
            pad_r <= 1'b0;
        end else if (soft_reset || cmd_phase == FHD_PH_IDLE) begin
            err_r <= 1'b0;
            pad_r <= 1'b0;
        end else if (cmd_phase == FHD_PH_EXEC && disk_byte_tick && !err_r) begin
            if (exec_read && fifo_full) begin
                err_r <= 1'b1;
            end else if (!exec_read && fifo_empty) begin
                err_r <= 1'b1;
                pad_r <= 1'b1;
            end
        end
    end

    assign xfer_error   = err_r;
    assign pad_zero_crc = pad_r;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rate_r <= `FHD_RATE_RST;
        end else if (bus_wr && bus_addr == `FHD_OFS_INSENSE) begin
            rate_r <= bus_wdata[1:0];
        end else if (dsr_rate_wr) begin
            rate_r <= dsr_rate;
        end
    end

    // Soft reset deliberately leaves noprec alone
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            noprec_r <= 1'b0;
        end else if (bus_wr && bus_addr == `FHD_OFS_INSENSE && compat_mode == FHD_MODE_THREE) begin
            noprec_r <= bus_wdata[`FHD_BIT_NOPREC];
        end
    end

    assign rate_select = rate_r;
    assign low_density_indicator = (rate_r == `FHD_RATE_250K) || (rate_r == `FHD_RATE_300K);

    always_comb begin
        sense = 8'h00;
        sense[`FHD_BIT_MEDIA] = !media_changed_pin_n || force_media_change;
        unique case (compat_mode)
            FHD_MODE_ONE: begin
                sense[6:0] = 7'h00;
            end
            FHD_MODE_TWO: begin
                sense[6:3] = 4'hF;
                sense[2:1] = rate_r;
                sense[0]   = low_density_indicator;
            end
            FHD_MODE_THREE: begin
                sense[6:4] = 3'h0;
                sense[`FHD_BIT_DMA]    = dma_gate_enable;
                sense[`FHD_BIT_NOPREC] = noprec_r;
                sense[1:0] = rate_r;
            end
            default: begin
                sense[6:0] = 7'h00;
            end
        endcase
    end

    // Offset 7 reads sense only; writes touch the config register
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            bus_rdata      <= 8'h00;
            bus_rdata_oe_n <= 8'hFF;
        end else if (bus_rd && bus_addr == `FHD_OFS_INSENSE) begin
            bus_rdata      <= sense;
            bus_rdata_oe_n <= (compat_mode == FHD_MODE_ONE) ? 8'h7F : 8'h00;
        end else if (data_rd) begin
            bus_rdata      <= mem_r[rp_r];
            bus_rdata_oe_n <= 8'h00;
        end else begin
            bus_rdata_oe_n <= 8'hFF;
        end
    end

    a_flush_empty: assert property (@(posedge clk) disable iff (!arst_n)
        flush |=> cnt_r == 5'h00) else $error("FIFO not flushed at execution entry");
    a_cmd_single: assert property (@(posedge clk) disable iff (!arst_n)
        cmd_phase == FHD_PH_CMD |-> cnt_r <= 5'h01) else $error("Command phase held more than one byte");
    a_gate_rd: assert property (@(posedge clk) disable iff (!arst_n)
        data_rd |-> host_request_flag && transfer_direction_flag) else $error("Read taken without permission");
    a_soft_fifo_off: assert property (@(posedge clk) disable iff (!arst_n)
        soft_reset |=> !fifo_en_r) else $error("FIFO enabled after reset");
    a_soft_keeps_rate: assert property (@(posedge clk) disable iff (!arst_n)
        soft_reset && !bus_wr && !dsr_rate_wr |=> $stable(rate_r)) else $error("Rate lost on soft reset");
    a_ccr_rate: assert property (@(posedge clk) disable iff (!arst_n)
        bus_wr && bus_addr == `FHD_OFS_INSENSE |=> rate_r == $past(bus_wdata[1:0])) else $error("Rate not loaded");
    a_at_tristate: assert property (@(posedge clk) disable iff (!arst_n)
        bus_rd && bus_addr == `FHD_OFS_INSENSE && compat_mode == FHD_MODE_ONE |=> bus_rdata_oe_n == 8'h7F)
        else $error("Low bits driven in first mode");
    a_underrun_pad: assert property (@(posedge clk) disable iff (!arst_n)
        cmd_phase == FHD_PH_EXEC && disk_byte_tick && !exec_read && fifo_empty && !err_r && !soft_reset
        |=> err_r && pad_r) else $error("Underrun not handled");
    a_ps_ones: assert property (@(posedge clk) disable iff (!arst_n)
        bus_rd && bus_addr == `FHD_OFS_INSENSE && compat_mode == FHD_MODE_TWO |=> bus_rdata[6:3] == 4'hF)
        else $error("Second mode filler bits wrong");
    a_m30_zero: assert property (@(posedge clk) disable iff (!arst_n)
        bus_rd && bus_addr == `FHD_OFS_INSENSE && compat_mode == FHD_MODE_THREE |=> bus_rdata[6:4] == 3'h0)
        else $error("Third mode zero bits wrong");

    c_exec_flush: cover property (@(posedge clk) disable iff (!arst_n) flush);
    c_service: cover property (@(posedge clk) disable iff (!arst_n) $rose(service_req));
    c_overrun: cover property (@(posedge clk) disable iff (!arst_n) $rose(err_r) && exec_read);
endmodule

// ===== dv/fhd_host_model.sv
// Host bus master model for the data port and register window
`timescale 1ns/1ns
module fhd_host_model (
    input  wire logic       clk,
    output logic      [2:0] bus_addr,
    output logic            bus_rd,
    output logic            bus_wr,
    output logic      [7:0] bus_wdata,
    input  wire logic [7:0] bus_rdata,
    input  wire logic [7:0] bus_rdata_oe_n
);
    logic [7:0] last_q;
    initial begin
        bus_addr = 3'h0;
        bus_rd = 1'b0;
        bus_wr = 1'b0;
        bus_wdata = 8'h00;
        last_q = 8'h00;
    end
    // Caller checks request and direction flags before data port use
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        bus_addr <= a;
        bus_wdata <= d;
        bus_wr <= 1'b1;
        @(posedge clk);
        bus_wr <= 1'b0;
        bus_wdata <= ~d;
        #1;
    endtask
    // Undriven lines show the inverse of the last level, not a lucky match
    task automatic rd(input logic [2:0] a, output logic [7:0] d, output logic [7:0] oe);
        @(posedge clk);
        bus_addr <= a;
        bus_rd <= 1'b1;
        @(posedge clk);
        bus_rd <= 1'b0;
        #1;
        oe = bus_rdata_oe_n;
        d = (bus_rdata & ~oe) | (~last_q & oe);
        last_q = d;
    endtask
endmodule

// ===== dv/floppy_host_data_and_input_regs_test.sv
// Self-checking bench for the host data port and sense registers
`timescale 1ns/1ns
module floppy_host_data_and_input_regs_test;
    import fhd_pkg::*;
    logic clk, arst_n, soft_reset, pin_n, force_mc, dma, dsr_wr, cfg_wr, fifo_en, exec_read;
    logic push, tick, pop;
    localparam int P_PUSH = 0;
    localparam int P_TICK = 1;
    localparam int P_CFG  = 2;
    localparam int P_SOFT = 3;
    localparam int P_DSR  = 4;
    localparam int P_POP  = 5;
    logic [1:0] dsr_rate;
    logic [3:0] thr;
    logic [7:0] wdata, d, oe;
    fhd_mode_t mode;
    fhd_phase_t phase;
    logic [2:0] addr;
    logic rd, wr, req, dir, svc, err, pad, lowd, empty, full;
    logic [7:0] bwd, rdata, oe_n, erd;
    logic [1:0] rate;
    int mismatches, compares;
    fhd_host_port fhd_host_port_i (.clk(clk), .arst_n(arst_n), .soft_reset(soft_reset),
        .compat_mode(mode), .bus_addr(addr), .bus_rd(rd), .bus_wr(wr), .bus_wdata(bwd),
        .bus_rdata(rdata), .bus_rdata_oe_n(oe_n), .media_changed_pin_n(pin_n),
        .force_media_change(force_mc), .dma_gate_enable(dma), .dsr_rate_wr(dsr_wr),
        .dsr_rate(dsr_rate), .cfg_wr(cfg_wr), .cfg_fifo_en(fifo_en), .cfg_threshold(thr),
        .cmd_phase(phase), .exec_read(exec_read), .eng_push(push), .eng_wdata(wdata),
        .eng_pop(pop), .eng_rdata(erd), .fifo_empty(empty), .fifo_full(full),
        .disk_byte_tick(tick), .host_request_flag(req), .transfer_direction_flag(dir),
        .service_req(svc), .xfer_error(err), .pad_zero_crc(pad), .rate_select(rate),
        .low_density_indicator(lowd));
    fhd_host_model fhd_host_model_i (.clk(clk), .bus_addr(addr), .bus_rd(rd), .bus_wr(wr),
        .bus_wdata(bwd), .bus_rdata(rdata), .bus_rdata_oe_n(oe_n));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic close_out();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // Strobe by code, since a ref target cannot take a nonblocking write
    task automatic pulse(input int which);
        @(posedge clk);
        case (which)
            P_PUSH: push <= 1'b1;
            P_TICK: tick <= 1'b1;
            P_CFG: cfg_wr <= 1'b1;
            P_SOFT: soft_reset <= 1'b1;
            P_DSR: dsr_wr <= 1'b1;
            default: pop <= 1'b1;
        endcase
        @(posedge clk);
        {push, tick, cfg_wr, soft_reset, dsr_wr, pop} <= '0;
        #1;
    endtask
    task automatic go_phase(input fhd_phase_t p);
        @(posedge clk);
        phase <= p;
        @(posedge clk);
        #1;
    endtask
    // Single-byte path, host read, then overrun on a full FIFO
    task automatic t_legacy();
        exec_read <= 1'b1;
        go_phase(FHD_PH_EXEC);
        wdata <= 8'hA5;
        pulse(P_PUSH);
        chk(full, 1'b1);
        chk({req, dir}, 2'b11);
        fhd_host_model_i.rd(3'h5, d, oe);
        chk(d, 8'hA5);
        pulse(P_PUSH);
        pulse(P_TICK);
        @(posedge clk);
        #1;
        chk(err, 1'b1);
        fhd_host_model_i.rd(3'h5, d, oe);
        chk(d, 8'hA5);
        chk(empty, 1'b1);
        go_phase(FHD_PH_IDLE);
    endtask
    // Write underrun pads the sector; engine takes the host byte
    task automatic t_underrun();
        exec_read <= 1'b0;
        go_phase(FHD_PH_EXEC);
        chk({req, dir}, 2'b10);
        fhd_host_model_i.wr(3'h5, 8'h5A);
        chk(erd, 8'h5A);
        chk(full, 1'b1);
        pulse(P_POP);
        chk(empty, 1'b1);
        pulse(P_TICK);
        chk({err, pad}, 2'b11);
        go_phase(FHD_PH_IDLE);
        chk({err, pad}, 2'b00);
    endtask
    // Threshold service request, flush on execution entry, soft reset drops FIFO mode
    task automatic t_fifo();
        fifo_en <= 1'b1;
        thr <= 4'h1;
        pulse(P_CFG);
        go_phase(FHD_PH_EXEC);
        pulse(P_PUSH);
        chk(svc, 1'b0);
        pulse(P_PUSH);
        chk(svc, 1'b1);
        chk(full, 1'b0);
        go_phase(FHD_PH_IDLE);
        go_phase(FHD_PH_EXEC);
        chk(empty, 1'b1);
        pulse(P_SOFT);
        pulse(P_PUSH);
        chk(full, 1'b1);
        go_phase(FHD_PH_IDLE);
    endtask
    // Mode layouts, rate sources, noprec across soft reset
    task automatic t_sense();
        mode <= FHD_MODE_THREE;
        fhd_host_model_i.wr(3'h7, 8'hFF);
        chk(rate, 2'h3);
        fhd_host_model_i.rd(3'h7, d, oe);
        chk(d, 8'h8F);
        pulse(P_SOFT);
        dma <= 1'b0;
        fhd_host_model_i.rd(3'h7, d, oe);
        chk(d, 8'h87);
        @(posedge clk);
        dsr_rate <= 2'h0;
        pulse(P_DSR);
        @(posedge clk);
        mode <= FHD_MODE_TWO;
        fhd_host_model_i.rd(3'h7, d, oe);
        chk(d, 8'hF8);
        chk(lowd, 1'b0);
        mode <= FHD_MODE_ONE;
        pin_n <= 1'b1;
        fhd_host_model_i.wr(3'h7, 8'hFD);
        chk(rate, 2'h1);
        fhd_host_model_i.rd(3'h7, d, oe);
        chk(oe, 8'h7F);
        chk(d[7], 1'b0);
        force_mc <= 1'b1;
        fhd_host_model_i.rd(3'h7, d, oe);
        chk(d[7], 1'b1);
    endtask
    initial begin
        {arst_n, soft_reset, force_mc, dsr_wr, cfg_wr, fifo_en, exec_read, push, tick, pop} = '0;
        pin_n = 1'b0;
        dma = 1'b1;
        dsr_rate = 2'h0;
        thr = 4'h0;
        wdata = 8'h3C;
        mode = FHD_MODE_TWO;
        phase = FHD_PH_IDLE;
        mismatches = 0;
        compares = 0;
        repeat (8) @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
        #1;
        chk(rate, 2'h2);
        t_legacy();
        t_fifo();
        t_underrun();
        t_sense();
        close_out();
    end
    initial begin
        #100000;
        mismatches++;
        close_out();
    end
endmodule
